// [rtl/rawd_rx_window_decoder.sv]
// receive address window decoder: five base/mask windows with translation
`timescale 1ns/1ns
`default_nettype none
module rawd_rx_window_decoder #(parameter int AW = 12)
(
  input  wire logic                            clk_sys,        // system clock, 25 MHz
  input  wire logic                            srst,           // sync reset, high
  input  wire logic                            ce,             // clock enable
  input  wire logic [AW-1:0]                   s_axi_awaddr,   // write address
  input  wire logic [2:0]                      s_axi_awprot,   // unused
  input  wire logic                            s_axi_awvalid,  // write address valid
  output logic                                 s_axi_awready,  // write address ready
  input  wire logic [31:0]                     s_axi_wdata,    // write data
  input  wire logic [3:0]                      s_axi_wstrb,    // byte strobes
  input  wire logic                            s_axi_wvalid,   // write data valid
  output logic                                 s_axi_wready,   // write data ready
  output logic [1:0]                           s_axi_bresp,    // write response
  output logic                                 s_axi_bvalid,   // write response valid
  input  wire logic                            s_axi_bready,   // write response ready
  input  wire logic [AW-1:0]                   s_axi_araddr,   // read address
  input  wire logic [2:0]                      s_axi_arprot,   // unused
  input  wire logic                            s_axi_arvalid,  // read address valid
  output logic                                 s_axi_arready,  // read address ready
  output logic [31:0]                          s_axi_rdata,    // read data
  output logic [1:0]                           s_axi_rresp,    // read response
  output logic                                 s_axi_rvalid,   // read data valid
  input  wire logic                            s_axi_rready,   // read data ready
  input  wire logic                            reqValid,       // link request present
  input  wire logic [rawd_pkg::IN_AW-1:0]      reqAddr,        // link request address
  output logic                                 cpuValid_ff,    // pulse: to processor side
  output logic                                 p2pValid_ff,    // pulse: back onto link
  output logic                                 dropValid_ff,   // pulse: no window hit
  output logic [rawd_pkg::OUT_AW-1:0]          outAddr_ff,     // routed address
  output logic [rawd_pkg::WIN_IDX_W-1:0]       outWindow_ff    // window that decided
);
  localparam int NW = rawd_pkg::NUM_WIN;

  logic [31:0]                    ctrl_ff   [NW];
  logic [31:0]                    bm_ff     [NW];
  logic [NW-1:0]                  p2pSel_ff;
  rawd_pkg::rawd_route_e          lastRoute_ff;
  logic [rawd_pkg::CNT_W-1:0]     reqCount_ff;

  logic [NW-1:0]                  hitVec;
  logic [rawd_pkg::OUT_AW-1:0]    xAddr     [NW];
  logic [rawd_pkg::ZCNT_W-1:0]    zeroCnt   [NW];
  logic [NW-1:0]                  wrCtrlSel;
  logic [NW-1:0]                  wrBmSel;
  logic [NW-1:0]                  rdCtrlSel;
  logic [NW-1:0]                  rdBmSel;

  logic                           wrEn;
  logic [AW-1:0]                  wrAddr;
  logic [31:0]                    wrData;
  logic [3:0]                     wrStrb;
  logic                           wrOk;
  logic [31:0]                    rdData;
  logic                           rdOk;

  logic                           anyHit;
  logic                           p2pHit;
  logic [rawd_pkg::WIN_IDX_W-1:0] selIdx;
  logic [rawd_pkg::OUT_AW-1:0]    selAddr;
  logic [31:0]                    statusWord;
  logic [31:0]                    sizeWord;

  function automatic logic [31:0] strbMerge(logic [31:0] oldV, logic [31:0] newV,
                                            logic [3:0] strb);
    logic [31:0] res;
    res = oldV;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[8*b +: 8] = newV[8*b +: 8];
    end
    return res;
  endfunction

  function automatic logic offsetIs(logic [AW-1:0] a, logic [11:0] ofs);
    return {a[AW-1:2], 2'b00} == AW'(ofs);
  endfunction

  rawd_axil_slave #(.AW(AW)) u_slave
  (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .ce            (ce),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrEn          (wrEn),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrStrb        (wrStrb),
    .wrOk          (wrOk),
    .rdData        (rdData),
    .rdOk          (rdOk)
  );

  // per-window registers and matcher
  for (genvar i = 0; i < NW; i++)
  begin : g_win
    assign wrCtrlSel[i] = offsetIs(wrAddr, rawd_pkg::CTRL_OFS[i]);
    assign wrBmSel[i]   = offsetIs(wrAddr, rawd_pkg::BMASK_OFS[i]);
    assign rdCtrlSel[i] = offsetIs(s_axi_araddr, rawd_pkg::CTRL_OFS[i]);
    assign rdBmSel[i]   = offsetIs(s_axi_araddr, rawd_pkg::BMASK_OFS[i]);

    always_ff @(posedge clk_sys)
    begin
      if (srst)
      begin
        ctrl_ff[i] <= rawd_pkg::CTRL_RST;
        bm_ff[i]   <= rawd_pkg::BMASK_RST;
      end
      else if (wrEn)
      begin
        if (wrCtrlSel[i])
          ctrl_ff[i] <= strbMerge(ctrl_ff[i], wrData, wrStrb);
        if (wrBmSel[i])
          bm_ff[i] <= strbMerge(bm_ff[i], wrData, wrStrb);
      end
    end

    rawd_win_match u_match
    (
      .ctrlReg (ctrl_ff[i]),
      .bmReg   (bm_ff[i]),
      .reqAddr (reqAddr),
      .hit     (hitVec[i]),
      .xAddr   (xAddr[i]),
      .zeroCnt (zeroCnt[i])
    );

    assign sizeWord[rawd_pkg::ZCNT_W*i +: rawd_pkg::ZCNT_W] = zeroCnt[i];
  end

  assign sizeWord[31:rawd_pkg::ZCNT_W*NW] = '0;

  // peer-to-peer marking is a plain bit per window; nothing stops software from
  // marking every window, which sends every hit back onto the link and leaves only misses to drop
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      p2pSel_ff <= rawd_pkg::P2PSEL_RST[NW-1:0];
    else if (wrEn && offsetIs(wrAddr, rawd_pkg::P2PSEL_OFS) && wrStrb[0])
      p2pSel_ff <= wrData[NW-1:0];  // all marks sit in byte lane 0
  end

  assign wrOk = (|wrCtrlSel) || (|wrBmSel) || offsetIs(wrAddr, rawd_pkg::P2PSEL_OFS)
             || offsetIs(wrAddr, rawd_pkg::STATUS_OFS) || offsetIs(wrAddr, rawd_pkg::SIZE_OFS);

  // lowest-numbered hit wins the translation
  always_comb
  begin
    selIdx  = '0;
    selAddr = {{rawd_pkg::HIGH_PAD_W{1'b0}}, reqAddr};
    for (int w = NW - 1; w >= 0; w--)
    begin
      if (hitVec[w])
      begin
        selIdx  = rawd_pkg::WIN_IDX_W'(w);
        selAddr = xAddr[w];
      end
    end
  end

  assign anyHit = |hitVec;
  assign p2pHit = |(hitVec & p2pSel_ff);

  // one-cycle routing stage; a request is taken on every enabled edge with reqValid
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      cpuValid_ff  <= 1'b0;
      p2pValid_ff  <= 1'b0;
      dropValid_ff <= 1'b0;
      outAddr_ff   <= '0;
      outWindow_ff <= '0;
    end
    else if (ce)
    begin
      p2pValid_ff  <= reqValid && p2pHit;
      cpuValid_ff  <= reqValid && anyHit && !p2pHit;
      dropValid_ff <= reqValid && !anyHit;
      if (reqValid)
      begin
        outAddr_ff   <= selAddr;
        outWindow_ff <= selIdx;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      lastRoute_ff <= rawd_pkg::RT_IDLE;
      reqCount_ff  <= '0;
    end
    else if (ce && reqValid)
    begin
      reqCount_ff <= reqCount_ff + 1'b1;
      if (p2pHit)
        lastRoute_ff <= rawd_pkg::RT_P2P;
      else if (anyHit)
        lastRoute_ff <= rawd_pkg::RT_CPU;
      else
        lastRoute_ff <= rawd_pkg::RT_DROP;
    end
  end

  always_comb
  begin
    statusWord = '0;
    statusWord[rawd_pkg::WIN_IDX_W-1:0] = outWindow_ff;
    statusWord[rawd_pkg::ST_CNT_LSB +: rawd_pkg::CNT_W] = reqCount_ff;
    case (lastRoute_ff)
      rawd_pkg::RT_CPU:  statusWord[rawd_pkg::ST_CPU_BIT]  = 1'b1;
      rawd_pkg::RT_P2P:  statusWord[rawd_pkg::ST_P2P_BIT]  = 1'b1;
      rawd_pkg::RT_DROP: statusWord[rawd_pkg::ST_DROP_BIT] = 1'b1;
      default:           statusWord[rawd_pkg::ST_CPU_BIT]  = 1'b0;
    endcase
  end

  always_comb
  begin
    rdData = 32'h00000000;
    rdOk   = 1'b1;
    if (|rdCtrlSel)
    begin
      for (int w = 0; w < NW; w++)
        if (rdCtrlSel[w])
          rdData = ctrl_ff[w];
    end
    else if (|rdBmSel)
    begin
      for (int w = 0; w < NW; w++)
        if (rdBmSel[w])
          rdData = bm_ff[w];
    end
    else if (offsetIs(s_axi_araddr, rawd_pkg::P2PSEL_OFS))
      rdData = {{(32-NW){1'b0}}, p2pSel_ff};
    else if (offsetIs(s_axi_araddr, rawd_pkg::STATUS_OFS))
      rdData = statusWord;
    else if (offsetIs(s_axi_araddr, rawd_pkg::SIZE_OFS))
      rdData = sizeWord;
    else
      rdOk = 1'b0;
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  route_excl_a: assert property (
    $onehot0({cpuValid_ff, p2pValid_ff, dropValid_ff}))
    else $error("more than one route pulse at once");

  p2p_route_a: assert property (
    ce && reqValid && |(hitVec & p2pSel_ff) |=> p2pValid_ff && !cpuValid_ff)
    else $error("peer-to-peer hit not sent back to the link");

  cpu_route_a: assert property (
    ce && reqValid && |hitVec && !(|(hitVec & p2pSel_ff)) |=> cpuValid_ff)
    else $error("normal hit not delivered to processor side");

  win_disabled_a: assert property (
    ce && reqValid && !ctrl_ff[0][rawd_pkg::EN_BIT] && !ctrl_ff[1][rawd_pkg::EN_BIT]
    && !ctrl_ff[2][rawd_pkg::EN_BIT] && !ctrl_ff[3][rawd_pkg::EN_BIT]
    && !ctrl_ff[4][rawd_pkg::EN_BIT] |=> dropValid_ff)
    else $error("request hit while all windows disabled");

  low_bits_a: assert property (
    $past(ce) && (cpuValid_ff || p2pValid_ff)
    |-> outAddr_ff[rawd_pkg::CMP_LSB-1:0] == $past(reqAddr[rawd_pkg::CMP_LSB-1:0]))
    else $error("address bits below the window were altered");

  pass_thru_a: assert property (
    ce && reqValid && hitVec[0] && !ctrl_ff[0][rawd_pkg::XLATE_BIT]
    |=> outAddr_ff == {{rawd_pkg::HIGH_PAD_W{1'b0}}, $past(reqAddr)})
    else $error("untranslated window changed the address");

  xlate_hi_a: assert property (
    ce && reqValid && hitVec[0] && ctrl_ff[0][rawd_pkg::XLATE_BIT]
    |=> outAddr_ff[rawd_pkg::OUT_AW-1:rawd_pkg::IN_AW]
        == $past(ctrl_ff[0][rawd_pkg::TRANS_W-1:rawd_pkg::FIELD_W]))
    else $error("translated upper bits wrong");

  win_prio_a: assert property (
    ce && reqValid && hitVec[0] |=> outWindow_ff == '0)
    else $error("lowest hitting window not chosen");

  hit_eq_a: assert property (
    hitVec[1] == (ctrl_ff[1][rawd_pkg::EN_BIT]
      && ((bm_ff[1][31:16] & bm_ff[1][15:0]) == (reqAddr[39:24] & bm_ff[1][15:0]))))
    else $error("window 1 hit disagrees with base and mask");

  size_cnt_a: assert property (
    sizeWord[rawd_pkg::ZCNT_W-1:0] == 5'(16 - $countones(bm_ff[0][15:0])))
    else $error("window 0 size disagrees with mask zeros");

  wr_ctrl_a: assert property (
    wrEn && wrCtrlSel[3] && wrStrb == 4'hF |=> ctrl_ff[3] == $past(wrData))
    else $error("window 3 control write lost");

  p2p_seen_c: cover property (ce && reqValid ##1 p2pValid_ff);
  cpu_seen_c: cover property (ce && reqValid ##1 cpuValid_ff);
  drop_seen_c: cover property (ce && reqValid ##1 dropValid_ff);
  multi_hit_c: cover property (ce && reqValid && !$onehot0(hitVec));
  xlate_seen_c: cover property (ce && reqValid && hitVec[0] && ctrl_ff[0][rawd_pkg::XLATE_BIT]);
endmodule // rawd_rx_window_decoder
`default_nettype wire

// [inc/rawd_pkg.sv]
// constants and types shared by the receive address window decoder
`default_nettype none
package rawd_pkg;
  localparam int          NUM_WIN     = 5;
  localparam logic [11:0] CTRL_OFS  [NUM_WIN] = '{12'h060, 12'h068, 12'h070, 12'h148, 12'h150};
  localparam logic [11:0] BMASK_OFS [NUM_WIN] = '{12'h064, 12'h06C, 12'h074, 12'h14C, 12'h154};
  localparam logic [11:0] P2PSEL_OFS  = 12'h158;
  localparam logic [11:0] STATUS_OFS  = 12'h15C;
  localparam logic [11:0] SIZE_OFS    = 12'h160;
  localparam logic [31:0] CTRL_RST    = 32'h00000000;
  localparam logic [31:0] BMASK_RST   = 32'h00000000;
  localparam logic [31:0] P2PSEL_RST  = 32'h00000000;
  localparam int          EN_BIT      = 31;
  localparam int          XLATE_BIT   = 30;
  localparam int          TRANS_W     = 30;
  localparam int          BASE_LSB    = 16;
  localparam int          FIELD_W     = 16;
  localparam int          CMP_LSB     = 24;
  localparam int          IN_AW       = 40;
  localparam int          OUT_AW      = 54;
  localparam int          HIGH_PAD_W  = OUT_AW - IN_AW;
  localparam int          ZCNT_W      = 5;
  localparam int          WIN_IDX_W   = 3;
  localparam int          ST_CPU_BIT  = 4;
  localparam int          ST_P2P_BIT  = 5;
  localparam int          ST_DROP_BIT = 6;
  localparam int          ST_CNT_LSB  = 16;
  localparam int          CNT_W       = 16;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [1:0]
  {
    RT_IDLE = 2'b00,
    RT_CPU  = 2'b01,
    RT_P2P  = 2'b10,
    RT_DROP = 2'b11
  } rawd_route_e;
endpackage
`default_nettype wire

// [rtl/rawd_win_match.sv]
// one receive window: compare, translate and size of its mask
`timescale 1ns/1ns
`default_nettype none
module rawd_win_match
(
  input  wire logic [31:0]                    ctrlReg,  // enable / translate register
  input  wire logic [31:0]                    bmReg,    // base / mask register
  input  wire logic [rawd_pkg::IN_AW-1:0]     reqAddr,  // address from the link
  output logic                                hit,      // window matches
  output logic [rawd_pkg::OUT_AW-1:0]         xAddr,    // outgoing address
  output logic [rawd_pkg::ZCNT_W-1:0]         zeroCnt   // zeros in the mask
);
  logic [rawd_pkg::FIELD_W-1:0] baseField;
  logic [rawd_pkg::FIELD_W-1:0] maskField;
  logic [rawd_pkg::FIELD_W-1:0] slice;

  assign baseField = bmReg[rawd_pkg::BASE_LSB +: rawd_pkg::FIELD_W];
  assign maskField = bmReg[rawd_pkg::FIELD_W-1:0];
  assign slice     = reqAddr[rawd_pkg::CMP_LSB +: rawd_pkg::FIELD_W];

  // disabled windows never hit
  assign hit = ctrlReg[rawd_pkg::EN_BIT] && ((baseField & maskField) == (slice & maskField));

  // translated bits 53:24 are OR-ed with the unmasked incoming bits
  assign xAddr = ctrlReg[rawd_pkg::XLATE_BIT]
    ? {ctrlReg[rawd_pkg::TRANS_W-1:0] | {{rawd_pkg::HIGH_PAD_W{1'b0}}, slice & ~maskField},
       reqAddr[rawd_pkg::CMP_LSB-1:0]}
    : {{rawd_pkg::HIGH_PAD_W{1'b0}}, reqAddr};

  // each zero in the mask doubles the window: size is 2**(24+zeroCnt) bytes
  always_comb
  begin
    zeroCnt = '0;
    for (int b = 0; b < rawd_pkg::FIELD_W; b++)
    begin
      zeroCnt = zeroCnt + {{(rawd_pkg::ZCNT_W-1){1'b0}}, ~maskField[b]};
    end
  end
endmodule // rawd_win_match
`default_nettype wire

// [rtl/rawd_axil_slave.sv]
// AXI4-Lite slave front end: handshakes, one write and one read in flight
`timescale 1ns/1ns
`default_nettype none
module rawd_axil_slave #(parameter int AW = 12)
(
  input  wire logic          clk_sys,        // system clock
  input  wire logic          srst,           // sync reset, high
  input  wire logic          ce,             // clock enable
  input  wire logic [AW-1:0] s_axi_awaddr,   // write address
  input  wire logic          s_axi_awvalid,  // write address valid
  output logic               s_axi_awready,  // write address ready
  input  wire logic [31:0]   s_axi_wdata,    // write data
  input  wire logic [3:0]    s_axi_wstrb,    // byte strobes
  input  wire logic          s_axi_wvalid,   // write data valid
  output logic               s_axi_wready,   // write data ready
  output logic [1:0]         s_axi_bresp,    // write response
  output logic               s_axi_bvalid,   // write response valid
  input  wire logic          s_axi_bready,   // write response ready
  input  wire logic          s_axi_arvalid,  // read address valid
  output logic               s_axi_arready,  // read address ready
  output logic [31:0]        s_axi_rdata,    // read data
  output logic [1:0]         s_axi_rresp,    // read response
  output logic               s_axi_rvalid,   // read data valid
  input  wire logic          s_axi_rready,   // read data ready
  output logic               wrEn,           // register write strobe
  output logic [AW-1:0]      wrAddr,         // register write address
  output logic [31:0]        wrData,         // register write data
  output logic [3:0]         wrStrb,         // register write strobes
  input  wire logic          wrOk,           // write address mapped
  input  wire logic [31:0]   rdData,         // read data for araddr
  input  wire logic          rdOk            // read address mapped
);
  logic awGot_ff;
  logic wGot_ff;

  assign wrEn = ce && awGot_ff && wGot_ff && !s_axi_bvalid;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      awGot_ff      <= 1'b0;
      s_axi_awready <= 1'b1;
      wrAddr        <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awGot_ff      <= 1'b1;
        s_axi_awready <= 1'b0;
        wrAddr        <= s_axi_awaddr;
      end
      else if (wrEn)
        awGot_ff <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wGot_ff      <= 1'b0;
      s_axi_wready <= 1'b1;
      wrData       <= '0;
      wrStrb       <= '0;
    end
    else if (ce)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        wGot_ff      <= 1'b1;
        s_axi_wready <= 1'b0;
        wrData       <= s_axi_wdata;
        wrStrb       <= s_axi_wstrb;
      end
      else if (wrEn)
        wGot_ff <= 1'b0;
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rawd_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (wrEn)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrOk ? rawd_pkg::RESP_OKAY : rawd_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read data is captured at the address handshake, so later writes do not tear it
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= rawd_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdOk ? rdData : 32'h00000000;
        s_axi_rresp   <= rdOk ? rawd_pkg::RESP_OKAY : rawd_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // rawd_axil_slave
`default_nettype wire

// [sim/rawd_link_agent.sv]
// link agent model: issues addressed requests toward the decoder
`timescale 1ns/1ns
`default_nettype none
module rawd_link_agent
(
  input  wire logic        clk_sys,   // system clock
  output logic             reqValid,  // request present
  output logic [39:0]      reqAddr    // request address
);
  initial
  begin
    reqValid = 1'h0;
    reqAddr  = 40'h0;
  end
  // no back-pressure exists, so one edge carries the whole request
  task automatic send(input logic [39:0] a);
    reqValid <= 1'h1;
    reqAddr  <= a;
    @(posedge clk_sys);
    reqValid <= 1'h0;
    reqAddr  <= ~a; // released lines show a changed pattern, never a stale copy
  endtask
endmodule // rawd_link_agent
`default_nettype wire

// [sim/rawd_rx_window_decoder_bench.sv]
// self-checking bench for the receive address window decoder
`timescale 1ns/1ns
`default_nettype none
module rawd_rx_window_decoder_bench;
  logic        clk_sys, srst, awV, awR, wV, wR, bV, bRd, arV, arR, rV, rRd, reqValid;
  logic        cpuValid_ff, p2pValid_ff, dropValid_ff;
  logic [11:0] awA, arA;
  logic [31:0] wD, rD;
  logic [1:0]  bRs, rRs;
  logic [39:0] reqAddr;
  logic [53:0] outAddr_ff;
  logic [2:0]  outWindow_ff;
  int          n_mismatch, compares;

  rawd_link_agent rawd_link_agent_inst
  (.clk_sys(clk_sys), .reqValid(reqValid), .reqAddr(reqAddr));

  rawd_rx_window_decoder rawd_rx_window_decoder_inst
  (
    .clk_sys(clk_sys), .srst(srst), .ce(1'h1), .s_axi_awaddr(awA), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bRs), .s_axi_bvalid(bV),
    .s_axi_bready(bRd), .s_axi_araddr(arA), .s_axi_arprot(3'h0), .s_axi_arvalid(arV),
    .s_axi_arready(arR), .s_axi_rdata(rD), .s_axi_rresp(rRs), .s_axi_rvalid(rV),
    .s_axi_rready(rRd), .reqValid(reqValid), .reqAddr(reqAddr), .cpuValid_ff(cpuValid_ff),
    .p2pValid_ff(p2pValid_ff), .dropValid_ff(dropValid_ff), .outAddr_ff(outAddr_ff),
    .outWindow_ff(outWindow_ff)
  );

  initial
  begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // the trailing edge keeps a following call from re-driving a signal in the same step
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awA <= a;
    wD  <= d;
    awV <= 1'h1;
    wV  <= 1'h1;
    bRd <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (awR) awV <= 1'h0;
      if (wR) wV <= 1'h0;
    end
    while (bV !== 1'h1);
    r = bRs;
    bRd <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    arA <= a;
    arV <= 1'h1;
    rRd <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (arR) arV <= 1'h0;
    end
    while (rV !== 1'h1);
    d = rD;
    r = rRs;
    rRd <= 1'h0;
    @(posedge clk_sys);
  endtask

  // rt is {cpu, peer_to_peer, drop}
  task automatic req(input logic [39:0] a, input logic [2:0] rt, input logic [53:0] o,
                     input logic [2:0] w);
    rawd_link_agent_inst.send(a);
    #1;
    chk("route", {cpuValid_ff, p2pValid_ff, dropValid_ff}, rt);
    chk("outAddr", outAddr_ff, o);
    chk("outWindow", outWindow_ff, w);
    @(posedge clk_sys);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axr(12'h154, d, r);
    chk("bm4 reset", {r, d}, 64'h0);
    axw(12'h148, 32'h5EADBEEF, r);
    axr(12'h148, d, r);
    chk("ctrl3 rw", {r, d}, {2'h0, 32'h5EADBEEF});
    axw(12'h004, 32'h1, r);
    chk("unmapped wr", r, 2'h2);
    axr(12'h004, d, r);
    chk("unmapped rd", {r, d}, {2'h2, 32'h0});
  endtask

  task automatic t_route;
    logic [31:0] d;
    logic [1:0]  r;
    axw(12'h060, 32'hC0000ABC, r);
    axw(12'h064, 32'h1200FF00, r);
    req(40'h12C356789A, 3'h4, {30'h0AFF, 24'h56789A}, 3'h0);
    req(40'h1300000001, 3'h1, 54'h1300000001, 3'h0);
    axw(12'h068, 32'h80000000, r);
    axw(12'h06C, 32'h1200FE00, r);
    axw(12'h158, 32'h2, r);
    req(40'h12FF000000, 3'h2, {30'h0AFF, 24'h0}, 3'h0);
    req(40'h1300000001, 3'h2, 54'h1300000001, 3'h1);
    axw(12'h060, 32'h40000ABC, r);
    req(40'h1234000000, 3'h2, 54'h1234000000, 3'h1);
    axr(12'h15C, d, r);
    chk("status", {r, d}, {2'h0, 32'h00050021});
    axr(12'h160, d, r);
    chk("size", {r, d}, {2'h0, 32'h01084128});
  endtask

  // mid-run reset: every window must come back disabled
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    srst <= 1'h1;
    @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    axr(12'h060, d, r);
    chk("ctrl0 reset", {r, d}, 64'h0);
    req(40'h1234000000, 3'h1, 54'h1234000000, 3'h0);
  endtask

  task automatic tally_and_finish;
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish();
  end

  initial
  begin
    {srst, awV, wV, bRd, arV, rRd, awA, arA, wD} = {1'h1, 5'h0, 24'h0, 32'h0};
    n_mismatch = 0;
    compares = 0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    t_regs();
    t_route();
    t_reset();
    tally_and_finish();
  end
endmodule // rawd_rx_window_decoder_bench
`default_nettype wire
